// ### src/lpm_power_ctrl.sv
// Power-mode controller: OFF, Standby and Normal sequencing for the LED driver
`default_nettype none
module lpm_power_ctrl (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Host pins, asynchronous
    input wire logic regulator_enable_pin,
    input wire logic chip_reset_low,
    input wire lpm_pkg::lpm_serial_s serial_pins,
    // Keep bits from the register block, same clock
    input wire lpm_pkg::lpm_keep_s keep_write,
    input wire logic keep_write_strobe,
    // Thermal shutdown from the sensor, asynchronous
    input wire logic thermal_trip,
    // Outputs from the logic core before gating
    input wire logic core_irq,
    input wire logic core_data_out,
    // Regulator enables and mode
    output lpm_pkg::lpm_reg_s regulators,
    output lpm_pkg::lpm_mode_e mode,
    // Serial gating towards the interface
    output logic serial_accept,
    output lpm_pkg::lpm_serial_s serial_gated,
    // Register default request and keep bits as held
    output logic register_default,
    output lpm_pkg::lpm_keep_s keep,
    // Pins back to the host
    output logic irq_pin,
    output logic data_out_pin
);
    import lpm_pkg::*;

    logic [2:0] pins_sync;
    logic enable_s;
    logic rstn_s;
    logic thermal_s;
    logic enable_d;
    logic enable_rise;
    logic [WAIT_W-1:0] wait_count;
    logic [WAIT_W-1:0] next_wait_count;
    lpm_mode_e next_mode;
    lpm_keep_s next_keep;
    lpm_reg_s next_regulators;
    logic next_enable_d;
    logic next_serial_accept;
    lpm_serial_s next_serial_gated;
    logic next_register_default;
    logic next_irq_pin;
    logic next_data_out_pin;
    logic thermal_hold;
    logic next_thermal_hold;
    logic [2:0] serial_sync;
    lpm_serial_s serial_s;

    // ==========================================================
    // Pin synchronisers
    lpm_sync #(.WIDTH(3)) u_pin_sync (
        .clock(clock),
        .reset(reset),
        .async_in({regulator_enable_pin, chip_reset_low, thermal_trip}),
        .sync_out(pins_sync)
    );
    lpm_sync #(.WIDTH(3)) u_serial_sync (
        .clock(clock),
        .reset(reset),
        .async_in(serial_pins),
        .sync_out(serial_sync)
    );
    assign enable_s = pins_sync[2];
    assign rstn_s = pins_sync[1];
    assign thermal_s = pins_sync[0];
    assign serial_s = serial_sync;
    assign enable_rise = enable_s && !enable_d;

    // ==========================================================
    // Mode state machine and keep bits
    always_comb begin
        next_mode = mode;
        next_enable_d = enable_s;
        next_keep = keep;
        next_thermal_hold = thermal_hold;
        // Logic stays in reset until the host pulses reset after a trip
        if (thermal_s) begin
            next_thermal_hold = 1'b1;
        end else if (!rstn_s) begin
            next_thermal_hold = 1'b0;
        end
        if (keep_write_strobe && rstn_s && serial_accept) begin
            next_keep = keep_write;
        end
        unique case (mode)
            LPM_OFF: begin
                if (enable_s) begin
                    next_mode = LPM_NORMAL;
                end
            end
            LPM_NORMAL: begin
                if (!enable_s && !keep.io_keep) begin
                    next_mode = LPM_OFF;
                end else if (!enable_s && enable_d && keep.io_keep && !keep.core_keep) begin
                    next_mode = LPM_STANDBY;
                end
            end
            LPM_STANDBY: begin
                // No exit to OFF from here; only a rising enable leaves
                if (enable_rise) begin
                    next_mode = LPM_NORMAL;
                end
            end
            default: next_mode = LPM_OFF;
        endcase
        // Defaults restore on reset pin, io regulator off or thermal trip
        if (!rstn_s || !regulators.io_on || thermal_s) begin
            next_keep = '{core_keep: CORE_KEEP_RESET, io_keep: IO_KEEP_RESET};
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            mode <= LPM_OFF;
            enable_d <= 1'b0;
            keep <= '{core_keep: CORE_KEEP_RESET, io_keep: IO_KEEP_RESET};
            thermal_hold <= 1'b0;
        end else begin
            mode <= next_mode;
            enable_d <= next_enable_d;
            keep <= next_keep;
            thermal_hold <= next_thermal_hold;
        end
    end

    // ==========================================================
    // Regulators, ready wait and serial gating
    always_comb begin
        // Thermal shutdown overrides the enable pin; keep bits only matter with enable low
        next_regulators.core_on = !thermal_s
            && (enable_s || (next_mode != LPM_OFF && keep.core_keep));
        next_regulators.io_on = !thermal_s
            && (enable_s || (next_mode != LPM_OFF && keep.io_keep));
        next_wait_count = wait_count;
        if (!enable_s) begin
            next_wait_count = '0;
        end else if (wait_count < WAIT_W'(READY_WAIT_CYCLES)) begin
            next_wait_count = wait_count + WAIT_W'(1);
        end
        // Ready needs enable high for the full wait, Normal mode and reset released
        next_serial_accept = enable_s && (wait_count == WAIT_W'(READY_WAIT_CYCLES))
            && (mode == LPM_NORMAL) && rstn_s && !thermal_hold;
        next_serial_gated = next_serial_accept ? serial_s : '0;
        next_register_default = !rstn_s || !regulators.io_on || thermal_hold;
        next_irq_pin = rstn_s && !thermal_hold && core_irq;
        next_data_out_pin = rstn_s && next_serial_accept && core_data_out;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            regulators <= '0;
            wait_count <= '0;
            serial_accept <= 1'b0;
            serial_gated <= '0;
            register_default <= 1'b1;
            irq_pin <= 1'b0;
            data_out_pin <= 1'b0;
        end else begin
            regulators <= next_regulators;
            wait_count <= next_wait_count;
            serial_accept <= next_serial_accept;
            serial_gated <= next_serial_gated;
            register_default <= next_register_default;
            irq_pin <= next_irq_pin;
            data_out_pin <= next_data_out_pin;
        end
    end

    // ==========================================================
    // Checks
    a_off_exit_enable: assert property (@(posedge clock) disable iff (reset)
        ($past(mode) == LPM_OFF && mode != LPM_OFF) |-> $past(enable_s))
        else $error("left OFF without enable");
    a_no_serial_low: assert property (@(posedge clock) disable iff (reset)
        (!enable_s && (!keep.core_keep || !keep.io_keep)) |=> !serial_accept)
        else $error("serial accepted with enable low and keep clear");
    a_standby_entry: assert property (@(posedge clock) disable iff (reset)
        (mode == LPM_NORMAL && !enable_s && enable_d && keep.io_keep && !keep.core_keep)
        |=> mode == LPM_STANDBY)
        else $error("standby not entered");
    a_standby_quiet: assert property (@(posedge clock) disable iff (reset)
        (mode == LPM_STANDBY) |=> !serial_accept)
        else $error("serial accepted in standby");
    a_standby_wake: assert property (@(posedge clock) disable iff (reset)
        (mode == LPM_STANDBY && enable_rise) |=> mode == LPM_NORMAL)
        else $error("standby not released by enable");
    a_standby_no_off: assert property (@(posedge clock) disable iff (reset)
        (mode == LPM_STANDBY) |=> mode != LPM_OFF)
        else $error("standby went to OFF");
    a_enable_regs_on: assert property (@(posedge clock) disable iff (reset)
        (enable_s && !thermal_s) |=> (regulators.core_on && regulators.io_on))
        else $error("regulator off with enable high");
    a_reset_blocks: assert property (@(posedge clock) disable iff (reset)
        !rstn_s |=> (!serial_accept && serial_gated == '0))
        else $error("serial passed during reset pin");
    a_ready_wait: assert property (@(posedge clock) disable iff (reset)
        $rose(serial_accept) |-> (wait_count == WAIT_W'(READY_WAIT_CYCLES)))
        else $error("serial ready before wait");
    a_reset_defaults: assert property (@(posedge clock) disable iff (reset)
        !rstn_s |=> (keep.core_keep && keep.io_keep && register_default))
        else $error("defaults not restored");
    a_reset_pins_low: assert property (@(posedge clock) disable iff (reset)
        !rstn_s |=> (!irq_pin && !data_out_pin))
        else $error("outputs not low in reset");
    a_thermal_quiet: assert property (@(posedge clock) disable iff (reset)
        thermal_hold |=> (!serial_accept && register_default))
        else $error("logic left reset state after thermal trip");
    c_off_to_normal: cover property (@(posedge clock) disable iff (reset)
        mode == LPM_OFF ##1 mode == LPM_NORMAL);
    c_normal_standby: cover property (@(posedge clock) disable iff (reset)
        mode == LPM_NORMAL ##1 mode == LPM_STANDBY);
    c_standby_normal: cover property (@(posedge clock) disable iff (reset)
        mode == LPM_STANDBY ##1 mode == LPM_NORMAL);
    c_serial_ready: cover property (@(posedge clock) disable iff (reset)
        $rose(serial_accept));
endmodule // lpm_power_ctrl
`default_nettype wire

// ### src/lpm_pkg.sv
// Package for the LED driver power-mode controller: states, timing, carriers
`default_nettype none
package lpm_pkg;
    // Clock and timing
    localparam int CLOCK_HZ = 125_000_000;
    localparam int READY_WAIT_US = 5000;
    localparam int READY_WAIT_CYCLES = (READY_WAIT_US * (CLOCK_HZ / 1_000_000));
    localparam int WAIT_W = 20;
    // Reset values of the keep bits
    localparam logic CORE_KEEP_RESET = 1'b1;
    localparam logic IO_KEEP_RESET = 1'b1;

    typedef enum logic [1:0] {
        LPM_OFF = 2'b00,
        LPM_STANDBY = 2'b01,
        LPM_NORMAL = 2'b10
    } lpm_mode_e;

    // Keep bits as written by the register block
    typedef struct packed {
        logic core_keep;
        logic io_keep;
    } lpm_keep_s;

    // Regulator enables
    typedef struct packed {
        logic core_on;
        logic io_on;
    } lpm_reg_s;

    // Serial port pins from the host
    typedef struct packed {
        logic chip_select;
        logic serial_clock;
        logic serial_data_in;
    } lpm_serial_s;
endpackage
`default_nettype wire

// ### src/lpm_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`default_nettype none
module lpm_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1 = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule // lpm_sync
`default_nettype wire

// ### sim/lpm_host.sv
// Host controller model driving the enable, reset and serial pins
`default_nettype none
module lpm_host
    import lpm_pkg::*;
(
    // Clock
    input wire logic clock,
    // Pins towards the device
    output logic regulator_enable_pin,
    output logic chip_reset_low,
    output lpm_pkg::lpm_serial_s serial_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Pin driving
    initial begin
        regulator_enable_pin = 1'b0;
        chip_reset_low = 1'b1;
        serial_pins = '0;
    end
    // Steps land on the falling edge only, so the pins never glitch
    task automatic set_pins(input logic enable, input logic rst_low);
        @(negedge clock);
        regulator_enable_pin = enable;
        chip_reset_low = rst_low;
    endtask
    // Idle serial lines rest low, as a host in reset must hold them
    task automatic frame(input logic [7:0] data);
        @(negedge clock);
        serial_pins.chip_select = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            serial_pins.serial_data_in = data[i];
            repeat (2) @(negedge clock);
            serial_pins.serial_clock = 1'b1;
            repeat (2) @(negedge clock);
            serial_pins.serial_clock = 1'b0;
        end
        @(negedge clock);
        serial_pins = '0;
    endtask
endmodule // lpm_host
`default_nettype wire

// ### sim/test_lpm_power_ctrl.sv
// Self-checking bench for the power-mode controller
`default_nettype none
module test_lpm_power_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import lpm_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic enable, rst_low, thermal_trip, core_irq, core_data_out, keep_write_strobe;
    lpm_serial_s serial_pins, serial_gated;
    lpm_keep_s keep_write, keep;
    lpm_reg_s regulators;
    lpm_mode_e mode;
    logic serial_accept, register_default, irq_pin, data_out_pin;
    int err_total = 0;
    int tests_run = 0;
    // Write value, expected keep bits, expected regulators
    logic [5:0] rows [4] = '{6'h03, 6'h17, 6'h2B, 6'h3F};
    always #4 clock = ~clock;
    lpm_host lpm_host_inst (.clock(clock), .regulator_enable_pin(enable),
        .chip_reset_low(rst_low), .serial_pins(serial_pins));
    lpm_power_ctrl lpm_power_ctrl_inst (.clock(clock), .reset(reset),
        .regulator_enable_pin(enable), .chip_reset_low(rst_low), .serial_pins(serial_pins),
        .keep_write(keep_write), .keep_write_strobe(keep_write_strobe),
        .thermal_trip(thermal_trip), .core_irq(core_irq), .core_data_out(core_data_out),
        .regulators(regulators), .mode(mode), .serial_accept(serial_accept),
        .serial_gated(serial_gated), .register_default(register_default), .keep(keep),
        .irq_pin(irq_pin), .data_out_pin(data_out_pin));
    // ==========================================
    // Tasks
    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_mode(input lpm_mode_e exp);
        tests_run++;
        if (mode !== exp) begin
            err_total++;
            $display("ERROR mode expected %h seen %h", exp, mode);
        end
    endtask
    task automatic settle;
        repeat (5) @(negedge clock);
    endtask
    task automatic end_test(input string name);
        $display("Test done: %s", name);
    endtask
    task automatic write_keep(input logic [1:0] v);
        @(negedge clock);
        keep_write = v;
        keep_write_strobe = 1'b1;
        @(negedge clock);
        keep_write_strobe = 1'b0;
    endtask
    // Frame sent while the gated copy is sampled mid-frame
    task automatic frame_chk(input logic [2:0] exp);
        fork
            lpm_host_inst.frame(8'hA5);
            begin
                repeat (6) @(negedge clock);
                chk("serial_gated", exp, serial_gated);
            end
        join
    endtask
    // Acceptance must stay off until the full wait has run out
    task automatic ready_chk;
        repeat (READY_WAIT_CYCLES - 12) @(negedge clock);
        chk("accept early", 3'h0, {2'h0, serial_accept});
        repeat (16) @(negedge clock);
        chk("accept late", 3'h1, {2'h0, serial_accept});
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==========================================
    // Sequence
    initial begin
        repeat (3 * READY_WAIT_CYCLES) @(posedge clock);
        err_total++;
        close_out();
    end
    initial begin
        keep_write = '0;
        keep_write_strobe = 1'b0;
        thermal_trip = 1'b0;
        core_irq = 1'b1;
        core_data_out = 1'b1;
        repeat (8) @(negedge clock);
        reset = 1'b0;
        chk_mode(LPM_OFF);
        chk("keep", 3'h3, {1'b0, keep});
        lpm_host_inst.set_pins(1'b1, 1'b1);
        settle();
        chk_mode(LPM_NORMAL);
        chk("regulators", 3'h3, {1'b0, regulators});
        ready_chk();
        frame_chk(3'h7);
        chk("irq data", 3'h3, {1'b0, irq_pin, data_out_pin});
        chk("default", 3'h0, {2'h0, register_default});
        end_test("power up");
        foreach (rows[i]) begin
            write_keep(rows[i][5:4]);
            repeat (3) @(negedge clock);
            chk("keep", {1'b0, rows[i][3:2]}, {1'b0, keep});
            chk("regulators", {1'b0, rows[i][1:0]}, {1'b0, regulators});
        end
        end_test("keep table");
        write_keep(2'h1);
        lpm_host_inst.set_pins(1'b0, 1'b1);
        settle();
        chk_mode(LPM_STANDBY);
        chk("regulators", 3'h1, {1'b0, regulators});
        chk("keep", 3'h1, {1'b0, keep});
        frame_chk(3'h0);
        chk_mode(LPM_STANDBY);
        lpm_host_inst.set_pins(1'b1, 1'b1);
        settle();
        chk_mode(LPM_NORMAL);
        end_test("standby");
        ready_chk();
        write_keep(2'h0);
        lpm_host_inst.set_pins(1'b0, 1'b1);
        lpm_host_inst.set_pins(1'b0, 1'b0);
        settle();
        chk_mode(LPM_OFF);
        chk("regulators", 3'h0, {1'b0, regulators});
        chk("default", 3'h1, {2'h0, register_default});
        chk("keep", 3'h3, {1'b0, keep});
        frame_chk(3'h0);
        lpm_host_inst.set_pins(1'b0, 1'b1);
        repeat (20) @(negedge clock);
        chk_mode(LPM_OFF);
        end_test("off");
        lpm_host_inst.set_pins(1'b1, 1'b1);
        settle();
        lpm_host_inst.set_pins(1'b1, 1'b0);
        settle();
        chk("regulators", 3'h3, {1'b0, regulators});
        chk("irq data", 3'h0, {1'b0, irq_pin, data_out_pin});
        chk("default", 3'h1, {2'h0, register_default});
        lpm_host_inst.set_pins(1'b1, 1'b1);
        end_test("reset pin");
        thermal_trip = 1'b1;
        settle();
        thermal_trip = 1'b0;
        settle();
        chk("regulators", 3'h3, {1'b0, regulators});
        chk("accept", 3'h0, {2'h0, serial_accept});
        chk("default", 3'h1, {2'h0, register_default});
        end_test("thermal");
        close_out();
    end
endmodule // test_lpm_power_ctrl
`default_nettype wire
